// [ilk_consts.vh]
// Constants for the interlock signal interface block.
`ifndef ILK_CONSTS_VH
`define ILK_CONSTS_VH

// ----------------------------------------------------------------
// Drive slots
// ----------------------------------------------------------------
`define ILK_NUM_DRIVES    9
`define ILK_DRV_AZ        0
`define ILK_DRV_EL        1
`define ILK_DRV_WRAP0     2
`define ILK_DRV_WRAP1     3
`define ILK_DRV_TWIST     4
`define ILK_DRV_CW0       5
`define ILK_NUM_AXIS      2
`define ILK_NUM_WRAP      3
`define ILK_NUM_CW        4
`define ILK_NUM_LIMITS    3

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define ILK_OFS_CTRL      12'h000
`define ILK_OFS_COND_SNAP 12'h004
`define ILK_OFS_EN_SNAP   12'h008
`define ILK_OFS_LIM_SNAP  12'h00C
`define ILK_OFS_IRQ_STAT  12'h010
`define ILK_OFS_IRQ_MASK  12'h014
`define ILK_OFS_COND_LIVE 12'h018

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define ILK_CTRL_ALLOW    0
`define ILK_IRQ_COND      0
`define ILK_IRQ_LIMIT     1
`define ILK_IRQ_REFRESH   2
`define ILK_IRQ_W         3
`define ILK_CTRL_RST      1'b0
`define ILK_MASK_RST      3'h0
`define ILK_SEQ_LSB       16

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define ILK_CLK_HZ        200000000
`define ILK_REFRESH_HZ    25
`define ILK_REFRESH_CYC   (`ILK_CLK_HZ / `ILK_REFRESH_HZ)

`endif

// [ilk_pin_sync.v]
// Three-stage pin synchroniser with agreement filter.
`timescale 1ns/1ps
module ilk_pin_sync #(
  parameter         W   = 1,
  parameter [W-1:0] RST = {W{1'b0}}
) (
  input  wire         pclk,
  input  wire         presetn,
  input  wire [W-1:0] pin_in,
  output wire [W-1:0] sync_out
);

  reg [W-1:0] s1_reg;
  reg [W-1:0] s2_reg;
  reg [W-1:0] s3_reg;
  reg [W-1:0] out_reg;
  wire [W-1:0] agree;
  wire [W-1:0] out_next;

  // A bit only moves once the second and third stages agree.
  assign agree    = ~(s2_reg ^ s3_reg);
  assign out_next = (s2_reg & agree) | (out_reg & ~agree);

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1_reg  <= RST;
      s2_reg  <= RST;
      s3_reg  <= RST;
      out_reg <= RST;
    end
    else
    begin
      s1_reg  <= pin_in;
      s2_reg  <= s1_reg;
      s3_reg  <= s2_reg;
      out_reg <= out_next;
    end
  end

  assign sync_out = out_reg;

endmodule // ilk_pin_sync

// [ilk_tick.v]
// Divider that gives a one-cycle enable pulse every CYCLES clocks.
`timescale 1ns/1ps
module ilk_tick #(
  parameter CYCLES = 8000000
) (
  input  wire pclk,
  input  wire presetn,
  output reg  tick
);

  localparam [31:0] LAST = CYCLES - 1;

  reg  [31:0] cnt_reg;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_reg <= 32'h0000_0000;
      tick    <= 1'b0;
    end
    else if (cnt_reg >= LAST)
    begin
      cnt_reg <= 32'h0000_0000;
      tick    <= 1'b1;
    end
    else
    begin
      cnt_reg <= cnt_reg + 32'h0000_0001;
      tick    <= 1'b0;
    end
  end

endmodule // ilk_tick

// [ilk_interface.v]
// Interlock interface: pair decode, enable pairs, limits, APB regs.
//
// Functional notes
// [RULE1] The interlock side sends each input as a true line and complement.
// [RULE2] A pair reads released only for true 0, complement 1, else asserted.
// [RULE3] Every output pair to the interlock side is a line and its inverse.
// [RULE4] The far side reads a pair clear only for true 0, complement 1.
// [RULE5] Pairs arrive for both axes, wraps, twister and 4 counterweights.
// [RULE6] Enable requests come from the axis servo for both main axes.
// [RULE7] Enable requests come from the wrap subsystem for wraps and twister.
// [RULE8] The counterweight subsystem gives an enable request per drive.
// [RULE9] Enable pairs are sent for axes, 2 wraps, twister, 4 counterweights.
// [RULE10] Decoded axis conditions are passed to the axis servo.
// [RULE11] Decoded wrap and twister conditions go to the wrap subsystem.
// [RULE12] Decoded weight drive conditions go to the counterweight subsystem.
// [RULE13] Every state is copied for the supervisory controller at 25 Hz.
// [RULE14] Azimuth near-limit indications are driven to the interlock side.
// [RULE15] An elevation near-limit indication goes to the interlock side.
// [RULE16] A released condition means amplifiers enabled and brakes released.
// [RULE17] Every incoming pin passes a synchroniser before any decoding.
`timescale 1ns/1ps
`include "ilk_consts.vh"
module ilk_interface #(
  parameter REFRESH_CYCLES = `ILK_REFRESH_CYC
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  output wire        irq,
  input  wire [8:0]  cond_true_in,
  input  wire [8:0]  cond_comp_in,
  input  wire [1:0]  axis_en_req,
  input  wire [2:0]  wrap_en_req,
  input  wire [3:0]  cw_en_req,
  output wire [1:0]  axis_condition_asserted,
  output wire [2:0]  wrap_condition_asserted,
  output wire [3:0]  cw_condition_asserted,
  output reg  [8:0]  en_true_out,
  output reg  [8:0]  en_comp_out,
  input  wire [1:0]  az_near_limit_in,
  input  wire        el_near_limit_in,
  output reg  [2:0]  limit_true_out,
  output reg  [2:0]  limit_comp_out
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  wire [8:0]  cond_true_s;
  wire [8:0]  cond_comp_s;
  wire [2:0]  limit_s;
  wire [8:0]  cond_word;
  wire [8:0]  en_word;
  wire        refresh_tick;
  wire        wr_en;
  wire        rd_setup;
  wire        cond_evt;
  wire        limit_evt;
  wire [2:0]  irq_events;
  wire        sel_ctrl;
  wire        sel_cond_snap;
  wire        sel_en_snap;
  wire        sel_lim_snap;
  wire        sel_irq_stat;
  wire        sel_irq_mask;
  wire        sel_cond_live;
  reg  [8:0]  cond_reg;
  reg  [8:0]  cond_prev_reg;
  reg  [2:0]  limit_prev_reg;
  reg         ctrl_allow_reg;
  reg  [8:0]  cond_snap_reg;
  reg  [8:0]  en_snap_reg;
  reg  [2:0]  lim_snap_reg;
  reg  [7:0]  seq_reg;
  reg  [2:0]  irq_stat_reg;
  reg  [2:0]  irq_stat_next;
  reg  [2:0]  irq_mask_reg;
  reg  [31:0] rd_word;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Released only for the exact pair 0/1; any other pattern,
  // including a broken or shorted cable, reads as asserted.
  function [8:0] pair_asserted;
    input [8:0] t;
    input [8:0] c;
    begin
      pair_asserted = ~(~t & c);
    end
  endfunction

  function mapped;
    input [11:0] a;
    begin
      if (a == `ILK_OFS_CTRL)
        mapped = 1'b1;
      else if (a == `ILK_OFS_COND_SNAP)
        mapped = 1'b1;
      else if (a == `ILK_OFS_EN_SNAP)
        mapped = 1'b1;
      else if (a == `ILK_OFS_LIM_SNAP)
        mapped = 1'b1;
      else if (a == `ILK_OFS_IRQ_STAT)
        mapped = 1'b1;
      else if (a == `ILK_OFS_IRQ_MASK)
        mapped = 1'b1;
      else if (a == `ILK_OFS_COND_LIVE)
        mapped = 1'b1;
      else
        mapped = 1'b0;
    end
  endfunction

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  // [RULE17] Synchronise condition lines.
  // True lines reset high so every pair decodes asserted until
  // the pins have been sampled; the safe reading comes first.
  ilk_pin_sync #(
    .W   (9),
    .RST (9'h1FF)
  ) u_sync_true (
    .pclk     (pclk),
    .presetn  (presetn),
    .pin_in   (cond_true_in),
    .sync_out (cond_true_s)
  );

  ilk_pin_sync #(
    .W   (9),
    .RST (9'h000)
  ) u_sync_comp (
    .pclk     (pclk),
    .presetn  (presetn),
    .pin_in   (cond_comp_in),
    .sync_out (cond_comp_s)
  );

  // [RULE17] Synchronise limit switches.
  ilk_pin_sync #(
    .W   (3),
    .RST (3'h0)
  ) u_sync_lim (
    .pclk     (pclk),
    .presetn  (presetn),
    .pin_in   ({el_near_limit_in, az_near_limit_in}),
    .sync_out (limit_s)
  );

  // ----------------------------------------------------------------
  // Condition decode
  // ----------------------------------------------------------------
  // [RULE2] [RULE5] Decode all nine pairs.
  assign cond_word = pair_asserted(cond_true_s, cond_comp_s);

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cond_reg       <= 9'h1FF;
      cond_prev_reg  <= 9'h1FF;
      limit_prev_reg <= 3'h0;
    end
    else
    begin
      cond_reg       <= cond_word;
      cond_prev_reg  <= cond_reg;
      limit_prev_reg <= limit_s;
    end
  end

  // [RULE10] [RULE16] Axis conditions to servo.
  assign axis_condition_asserted = cond_reg[`ILK_DRV_EL:`ILK_DRV_AZ];
  // [RULE11] Wraps and twister.
  assign wrap_condition_asserted = cond_reg[`ILK_DRV_TWIST:`ILK_DRV_WRAP0];
  // [RULE12] Counterweights.
  assign cw_condition_asserted   = cond_reg[8:`ILK_DRV_CW0];

  // ----------------------------------------------------------------
  // Enable and limit outputs
  // ----------------------------------------------------------------
  // [RULE6] [RULE7] [RULE8] Collect enable requests.
  // Software must open the gate after reset; until then every
  // enable pair reads clear on the interlock side, so no request
  // made before software is ready can power a drive.
  assign en_word = {cw_en_req, wrap_en_req, axis_en_req}
                 & {9{ctrl_allow_reg}};

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      en_true_out    <= 9'h000;
      en_comp_out    <= 9'h1FF;
    end
    else
    begin
      // [RULE9] [RULE3] Enable pairs out.
      en_true_out    <= en_word;
      en_comp_out    <= ~en_word;
    end
  end

  // [RULE14] [RULE15] [RULE3] Near-limit pairs out.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      limit_true_out <= 3'h0;
      limit_comp_out <= 3'h7;
    end
    else
    begin
      limit_true_out <= limit_s;
      limit_comp_out <= ~limit_s;
    end
  end

  // ----------------------------------------------------------------
  // Supervisory snapshot
  // ----------------------------------------------------------------
  ilk_tick #(
    .CYCLES (REFRESH_CYCLES)
  ) u_tick (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (refresh_tick)
  );

  // [RULE13] Periodic refresh of all states.
  // A snapshot keeps the fields coherent with each other; the live
  // condition register is there for faster polling when needed.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cond_snap_reg <= 9'h1FF;
      en_snap_reg   <= 9'h000;
      lim_snap_reg  <= 3'h0;
      seq_reg       <= 8'h00;
    end
    else if (refresh_tick)
    begin
      cond_snap_reg <= cond_reg;
      en_snap_reg   <= en_true_out;
      lim_snap_reg  <= limit_true_out;
      seq_reg       <= seq_reg + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  assign cond_evt   = |(cond_reg ^ cond_prev_reg);
  assign limit_evt  = |(limit_s ^ limit_prev_reg);
  assign irq_events = {refresh_tick, limit_evt, cond_evt};

  // A new event wins over a write-one-to-clear in the same cycle.
  always @*
  begin
    irq_stat_next = irq_stat_reg;
    if (wr_en && sel_irq_stat)
      irq_stat_next = irq_stat_reg & ~pwdata[`ILK_IRQ_W-1:0];
    irq_stat_next = irq_stat_next | irq_events;
  end

  // Sticky status, so irq stays high until software clears the bit.
  assign irq = |(irq_stat_reg & irq_mask_reg);

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  assign wr_en    = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign pready   = 1'b1;
  // An unmapped access flags an error and changes no register.
  assign pslverr  = psel & penable & ~mapped(paddr);

  // One compare per register, shared by the write and read paths.
  assign sel_ctrl      = (paddr == `ILK_OFS_CTRL);
  assign sel_cond_snap = (paddr == `ILK_OFS_COND_SNAP);
  assign sel_en_snap   = (paddr == `ILK_OFS_EN_SNAP);
  assign sel_lim_snap  = (paddr == `ILK_OFS_LIM_SNAP);
  assign sel_irq_stat  = (paddr == `ILK_OFS_IRQ_STAT);
  assign sel_irq_mask  = (paddr == `ILK_OFS_IRQ_MASK);
  assign sel_cond_live = (paddr == `ILK_OFS_COND_LIVE);

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_allow_reg <= `ILK_CTRL_RST;
      irq_mask_reg   <= `ILK_MASK_RST;
      irq_stat_reg   <= 3'h0;
    end
    else
    begin
      irq_stat_reg <= irq_stat_next;
      if (wr_en && sel_ctrl)
        ctrl_allow_reg <= pwdata[`ILK_CTRL_ALLOW];
      if (wr_en && sel_irq_mask)
        irq_mask_reg <= pwdata[`ILK_IRQ_W-1:0];
    end
  end

  always @*
  begin
    rd_word = 32'h0000_0000;
    if (sel_ctrl)
      rd_word[`ILK_CTRL_ALLOW] = ctrl_allow_reg;
    else if (sel_cond_snap)
      rd_word[8:0] = cond_snap_reg;
    else if (sel_en_snap)
      rd_word[8:0] = en_snap_reg;
    else if (sel_lim_snap)
    begin
      rd_word[2:0] = lim_snap_reg;
      rd_word[`ILK_SEQ_LSB+7:`ILK_SEQ_LSB] = seq_reg;
    end
    else if (sel_irq_stat)
      rd_word[`ILK_IRQ_W-1:0] = irq_stat_reg;
    else if (sel_irq_mask)
      rd_word[`ILK_IRQ_W-1:0] = irq_mask_reg;
    else if (sel_cond_live)
      rd_word[8:0] = cond_reg;
    else
      rd_word = 32'h0000_0000;
  end

  // Read data is captured in the setup cycle so that it comes from a
  // flip-flop while pready stays high in the access cycle.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (rd_setup)
      prdata <= rd_word;
  end

endmodule // ilk_interface

// [ilk_monitor.sv]
// Port-level concurrent checks for the interlock interface.
`timescale 1ns/1ps
module ilk_monitor (
  input wire       pclk,
  input wire       presetn,
  input wire       psel,
  input wire       penable,
  input wire       pslverr,
  input wire [8:0] cond_true_in,
  input wire [8:0] cond_comp_in,
  input wire [1:0] axis_en_req,
  input wire [2:0] wrap_en_req,
  input wire [3:0] cw_en_req,
  input wire [1:0] axis_condition_asserted,
  input wire [2:0] wrap_condition_asserted,
  input wire [3:0] cw_condition_asserted,
  input wire [8:0] en_true_out,
  input wire [8:0] en_comp_out,
  input wire [1:0] az_near_limit_in,
  input wire       el_near_limit_in,
  input wire [2:0] limit_true_out,
  input wire [2:0] limit_comp_out
);
  // The pin chain needs several cycles to fill after reset.
  reg  [3:0] up_cnt;
  wire       up_ok = up_cnt[3];
  always @(posedge pclk or negedge presetn)
    if (!presetn)
      up_cnt <= 4'h0;
    else if (!up_ok)
      up_cnt <= up_cnt + 4'h1;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_EN_PAIR: assert property (
    en_comp_out == ~en_true_out) else $error("enable pair broken");
  AST_LIM_PAIR: assert property (
    limit_comp_out == ~limit_true_out) else $error("limit pair broken");
  AST_COND_DECODE: assert property (
    (up_ok && $stable({cond_true_in, cond_comp_in}))[*7] |->
    {cw_condition_asserted, wrap_condition_asserted,
     axis_condition_asserted} == (cond_true_in | ~cond_comp_in))
    else $error("condition decode wrong");
  AST_LIM_FOLLOW: assert property (
    (up_ok && $stable({el_near_limit_in, az_near_limit_in}))[*7] |->
    limit_true_out == {el_near_limit_in, az_near_limit_in})
    else $error("limit output wrong");
  AST_AXIS_EN: assert property (
    (en_true_out[1:0] & ~$past(axis_en_req)) == 2'b00)
    else $error("axis enable without request");
  AST_WRAP_EN: assert property (
    (en_true_out[4:2] & ~$past(wrap_en_req)) == 3'b000)
    else $error("wrap enable without request");
  AST_CW_EN: assert property (
    (en_true_out[8:5] & ~$past(cw_en_req)) == 4'h0)
    else $error("weight enable without request");
  AST_ERR_PHASE: assert property (
    pslverr |-> psel && penable) else $error("error outside access");
endmodule // ilk_monitor
bind ilk_interface ilk_monitor u_ilk_monitor (.pclk, .presetn, .psel,
  .penable, .pslverr, .cond_true_in, .cond_comp_in, .axis_en_req,
  .wrap_en_req, .cw_en_req, .axis_condition_asserted,
  .wrap_condition_asserted, .cw_condition_asserted, .en_true_out,
  .en_comp_out, .az_near_limit_in, .el_near_limit_in, .limit_true_out,
  .limit_comp_out);

// [ilk_far_model.sv]
// Behavioural model of the interlock controller.
`timescale 1ns/1ps
module ilk_far_model (
  input  wire       pclk,
  input  wire [8:0] cond_set,
  input  wire [1:0] pair_mode,
  input  wire [8:0] en_true,
  input  wire [8:0] en_comp,
  output reg  [8:0] cond_true,
  output reg  [8:0] cond_comp,
  output wire [8:0] en_granted
);
  // complementary pairs
  // Modes 1 and 2 drive equal lines on purpose to probe the decoder.
  always @(posedge pclk)
  begin
    cond_true <= pair_mode[1] ? 9'h1ff : pair_mode[0] ? 9'h000 : cond_set;
    cond_comp <= pair_mode[1] ? 9'h1ff : pair_mode[0] ? 9'h000 : ~cond_set;
  end
  assign en_granted = en_true | ~en_comp;
endmodule // ilk_far_model

// [ilk_tb.sv]
// Self-checking testbench for the interlock interface.
`timescale 1ns/1ps
`include "ilk_consts.vh"
module tb;
  reg         pclk, presetn, psel, penable, pwrite, err, el_near_limit_in;
  reg  [11:0] paddr;
  reg  [31:0] pwdata, rd;
  reg  [1:0]  axis_en_req, az_near_limit_in, pair_mode;
  reg  [2:0]  wrap_en_req;
  reg  [3:0]  cw_en_req;
  reg  [8:0]  cond_set, cond_exp;
  wire [31:0] prdata;
  wire        pready, pslverr, irq;
  wire [8:0]  cond_true_in, cond_comp_in, en_true_out, en_comp_out;
  wire [8:0]  en_granted;
  wire [1:0]  axis_condition_asserted;
  wire [2:0]  wrap_condition_asserted, limit_true_out, limit_comp_out;
  wire [3:0]  cw_condition_asserted;
  integer     failures, checked;
  ilk_interface #(.REFRESH_CYCLES(20)) u_ilk_interface (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .irq, .cond_true_in, .cond_comp_in, .axis_en_req, .wrap_en_req,
    .cw_en_req, .axis_condition_asserted, .wrap_condition_asserted,
    .cw_condition_asserted, .en_true_out, .en_comp_out, .az_near_limit_in,
    .el_near_limit_in, .limit_true_out, .limit_comp_out);
  ilk_far_model u_ilk_far_model (.pclk, .cond_set, .pair_mode,
    .en_true(en_true_out), .en_comp(en_comp_out), .cond_true(cond_true_in),
    .cond_comp(cond_comp_in), .en_granted);
  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  task wrap_up;
  begin
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
  begin
    checked = checked + 1;
    if (got !== exp)
    begin
      failures = failures + 1;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  end
  endtask
  task cyc(input integer n);
    repeat (n) @(posedge pclk);
  endtask
  task apb(input w, input [11:0] a, input [31:0] d);
    integer n;
  begin
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    n = 0;
    while (pready !== 1'b1)
    begin
      n = n + 1;
      if (n > 20)
      begin
        failures = failures + 1;
        wrap_up;
      end
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  end
  endtask
  task t_reset;
  begin
    chk(en_true_out, 0);
    chk(en_comp_out, 9'h1ff);
    chk(limit_comp_out, 3'h7);
    chk(axis_condition_asserted, 2'h3);
    chk(irq, 0);
    chk(pready, 1);
    apb(0, `ILK_OFS_CTRL, 0);
    chk(rd, 0);
    apb(0, `ILK_OFS_IRQ_MASK, 0);
    chk(rd, 0);
    $display("reset test done");
  end
  endtask
  task t_decode;
    integer i;
    reg [8:0] prev;
  begin
    for (i = 0; i < 6; i = i + 1)
    begin
      prev = cond_exp;
      cond_set <= (i == 1) ? 9'h0a5 : (i == 2) ? 9'h15a : 9'h000;
      pair_mode <= (i == 3) ? 2'd1 : (i == 4) ? 2'd2 : 2'd0;
      cond_exp = (i == 1) ? 9'h0a5 : (i == 2) ? 9'h15a : 9'h000;
      if (i == 3 || i == 4)
        cond_exp = 9'h1ff;
      cyc(5);
      chk(axis_condition_asserted, prev[1:0]);
      chk(cw_condition_asserted, prev[8:5]);
      cyc(4);
      chk(axis_condition_asserted, cond_exp[1:0]);
      chk(wrap_condition_asserted, cond_exp[4:2]);
      chk(cw_condition_asserted, cond_exp[8:5]);
      apb(0, `ILK_OFS_COND_LIVE, 0);
      chk(rd, cond_exp);
    end
    $display("decode test done");
  end
  endtask
  task t_snap;
    reg [7:0] s0;
  begin
    apb(0, `ILK_OFS_LIM_SNAP, 0);
    s0 = rd[23:16];
    cyc(17);
    apb(0, `ILK_OFS_LIM_SNAP, 0);
    chk(rd[23:16], {24'h0, s0 + 8'h01});
    apb(0, `ILK_OFS_COND_SNAP, 0);
    chk(rd, cond_exp);
    apb(0, `ILK_OFS_EN_SNAP, 0);
    chk(rd, 9'h15a);
  end
  endtask
  task t_enable;
    integer i;
    reg [8:0] p;
  begin
    apb(1, `ILK_OFS_CTRL, 1);
    for (i = 0; i < 3; i = i + 1)
    begin
      p = (i == 0) ? 9'h1ff : (i == 1) ? 9'h0a5 : 9'h15a;
      {cw_en_req, wrap_en_req, axis_en_req} <= p;
      cyc(2);
      chk(en_true_out, p);
      chk(en_comp_out, {23'h0, ~p});
      chk(en_granted, p);
    end
    t_snap;
    apb(1, `ILK_OFS_CTRL, 0);
    cyc(2);
    chk(en_granted, 0);
    $display("enable test done");
  end
  endtask
  task t_limit;
    integer i;
    reg [2:0] lp;
  begin
    for (i = 0; i < 3; i = i + 1)
    begin
      lp = (i == 0) ? 3'b101 : (i == 1) ? 3'b010 : 3'b000;
      {el_near_limit_in, az_near_limit_in} <= lp;
      cyc(8);
      chk(limit_true_out, lp);
      chk(limit_comp_out, {29'h0, ~lp});
    end
    $display("limit test done");
  end
  endtask
  task t_irq;
  begin
    apb(1, `ILK_OFS_IRQ_MASK, 0);
    apb(1, `ILK_OFS_IRQ_STAT, 7);
    cond_set <= 9'h1ff;
    cond_exp = 9'h1ff;
    cyc(9);
    chk(irq, 0);
    apb(0, `ILK_OFS_IRQ_STAT, 0);
    chk(rd[0], 1);
    apb(1, `ILK_OFS_IRQ_MASK, 1);
    cyc(1);
    chk(irq, 1);
    apb(1, `ILK_OFS_IRQ_STAT, 1);
    cyc(1);
    chk(irq, 0);
    apb(0, 12'h01c, 0);
    chk(err, 1);
    chk(rd, 0);
    $display("irq test done");
  end
  endtask
  initial
  begin
    failures = 0;
    checked = 0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = 0;
    {axis_en_req, wrap_en_req, cw_en_req} = 0;
    {el_near_limit_in, az_near_limit_in} = 0;
    cond_set = 9'h1ff;
    cond_exp = 9'h1ff;
    pair_mode = 2'd0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset;
    t_decode;
    t_enable;
    t_limit;
    t_irq;
    wrap_up;
  end
endmodule // tb
